// >>> tb/peripheral_enable_lock_mux_asserts.sv
// Purpose: port checks for the enable/lock block
// Assumes: one-cycle request, answer on the next edge
// Notes: bound to the top module below
`timescale 1ns/100ps
`include "pin_steer_regs.svh"
module enable_lock_asserts (
    // clock, reset, bus
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic CFG_REQ_I,
    input wire logic CFG_WE_I,
    input wire logic [31:0] CFG_ADDR_I,
    input wire logic CFG_ACK_O,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic [31:0] STATUS_WORD_I,
    // enables and pins
    input wire logic VIDEO_A_ON_O,
    input wire logic VIDEO_B_ON_O,
    input wire logic VIDEO_C_ON_O,
    input wire logic TWOWIRE_ON_O,
    input wire logic SERIAL_A_ON_O,
    input wire logic SERIAL_B_ON_O,
    input wire logic AUDIO_ON_O,
    input wire logic VIDEO_A_LOW_PINS_O,
    input wire logic VIDEO_B_LOW_PINS_O,
    input wire logic VIDEO_UPPER_PINS_O
);
    // enables and pins lag one edge behind the enable register, hence the past guards
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    wire logic wr_sel = CFG_REQ_I && CFG_WE_I
        && CFG_ADDR_I == `ADDR_ENABLE_SELECT;
    wire logic [6:0] ons = {VIDEO_C_ON_O, VIDEO_B_ON_O, VIDEO_A_ON_O,
        TWOWIRE_ON_O, SERIAL_B_ON_O, SERIAL_A_ON_O, AUDIO_ON_O};
    sequence cfg_read(logic [31:0] a);
        CFG_REQ_I && !CFG_WE_I && CFG_ADDR_I == a;
    endsequence
    ack_pulse_a: assert property (CFG_REQ_I |=> CFG_ACK_O)
        else $error("request not answered");
    ack_quiet_a: assert property (!CFG_REQ_I |=> !CFG_ACK_O)
        else $error("answer without request");
    lock_rsvd_a: assert property (cfg_read(`ADDR_UNLOCK_KEY)
        |=> CFG_RDATA_O[31:1] == 31'h0) else $error("lock upper bits set");
    status_read_a: assert property (cfg_read(`ADDR_STATUS_WORD)
        |=> CFG_RDATA_O == $past(STATUS_WORD_I)) else $error("status bad");
    vid_a_low_a: assert property (!$past(RST_I) |->
        VIDEO_A_LOW_PINS_O == (VIDEO_A_ON_O && !SERIAL_A_ON_O))
        else $error("video a low pins wrong");
    vid_b_low_a: assert property (!$past(RST_I) |->
        VIDEO_B_LOW_PINS_O == (VIDEO_B_ON_O && !SERIAL_B_ON_O))
        else $error("video b low pins wrong");
    upper_pins_a: assert property (!$past(RST_I) |->
        VIDEO_UPPER_PINS_O == !AUDIO_ON_O) else $error("upper pins wrong");
    enable_hold_a: assert property (!$past(wr_sel, 2)
        && !$past(RST_I, 2) |-> $stable(ons)) else $error("enables moved");
endmodule
bind peripheral_enable_lock_mux enable_lock_asserts u_chk (.*);

// >>> tb/peripheral_enable_lock_mux_tb.sv
// Purpose: self-checking bench for the enable/lock block
// Assumes: answer one cycle after each request
// Notes: an integer model predicts every answer and output
`timescale 1ns/100ps
`include "pin_steer_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
module peripheral_enable_lock_mux_tb;
    logic clk = 0, rst = 1, req = 0, we = 0, ack;
    logic [31:0] addr = 0, wdata = 0, stat = 0, rdata;
    logic va, vb, vc, tw, sa, sb, au, al, bl, up;
    int n_fail = 0, n_tests = 0, seed = 48, lock_m = 1;
    int en_m = `ENABLE_RESET;
    int rd_q[$];
    logic [31:0] val;
    peripheral_enable_lock_mux u_peripheral_enable_lock_mux (
        .SYS_CLK_I(clk), .RST_I(rst), .CFG_REQ_I(req), .CFG_WE_I(we),
        .CFG_ADDR_I(addr), .CFG_WDATA_I(wdata), .CFG_ACK_O(ack),
        .CFG_RDATA_O(rdata), .STATUS_WORD_I(stat), .VIDEO_A_ON_O(va),
        .VIDEO_B_ON_O(vb), .VIDEO_C_ON_O(vc), .TWOWIRE_ON_O(tw),
        .SERIAL_A_ON_O(sa), .SERIAL_B_ON_O(sb), .AUDIO_ON_O(au),
        .VIDEO_A_LOW_PINS_O(al), .VIDEO_B_LOW_PINS_O(bl),
        .VIDEO_UPPER_PINS_O(up));
    // one access; model updates before the answer is judged
    task automatic acc(input logic w, input logic [31:0] a, d);
        int e;
        @(posedge clk); #1;
        req = 1; we = w; addr = a; wdata = d;
        e = (a == `ADDR_ENABLE_SELECT) ? en_m : (a == `ADDR_UNLOCK_KEY) ?
            lock_m : (a == `ADDR_STATUS_WORD) ? stat : 0;
        rd_q.push_back(e);
        if (w && a == `ADDR_UNLOCK_KEY) lock_m = (d != `UNLOCK_KEY_VALUE);
        if (w && a == `ADDR_ENABLE_SELECT) begin
            if (!lock_m) en_m = d[6:0];
            lock_m = 1;
        end
        @(posedge clk); #1;
        req = 0;
        e = rd_q.pop_front();
        `CHK(ack, 1'b1)
        if (!w) `CHK(rdata, e[31:0])
        // enables and pins trail the register by one more edge
        @(posedge clk); #1;
        `CHK(ack, 1'b0)
        `CHK({vc, vb, va, tw, sb, sa, au}, en_m[6:0])
        `CHK(al, ~en_m[1] & en_m[4])
        `CHK(bl, ~en_m[2] & en_m[5])
        `CHK(up, ~en_m[0])
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // free-running 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    // guard against a hang; the run needs far fewer cycles
    initial begin
        #100000;
        n_fail++;
        give_verdict;
    end
    // every fourth unlock uses a random key to test refusal
    // no peripheral is accessed, so pins switch freely
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        acc(0, `ADDR_ENABLE_SELECT, 0);
        acc(1, `ADDR_ENABLE_SELECT, 32'h7F);
        for (int i = 0; i < 20; i++) begin
            stat = $random(seed);
            wdata = (i % 4 == 3) ? $random(seed) : `UNLOCK_KEY_VALUE;
            acc(1, `ADDR_UNLOCK_KEY, wdata);
            acc(0, `ADDR_UNLOCK_KEY, 0);
            // all wanted enables go in one write
            val = i < 7 ? 1 << i : $random(seed);
            acc(1, `ADDR_ENABLE_SELECT, val);
            acc(0, `ADDR_UNLOCK_KEY, 0);
            acc(0, `ADDR_ENABLE_SELECT, 0);
            if (i == 0) repeat (`WAKE_TIME_CYCLES) @(posedge clk);
            acc(1, `ADDR_ENABLE_SELECT, $random(seed));
            acc(0, `ADDR_STATUS_WORD, 0);
            acc(i[0], 32'h01B3F008, $random(seed));
        end
        // a second reset must bring back the locked, serial-only state
        rst = 1;
        repeat (3) @(posedge clk);
        #1;
        `CHK({vc, vb, va, tw, sb, sa, au}, `ENABLE_RESET)
        `CHK(up, 1'b1)
        rst = 0;
        en_m = `ENABLE_RESET;
        lock_m = 1;
        acc(0, `ADDR_UNLOCK_KEY, 0);
        acc(0, `ADDR_ENABLE_SELECT, 0);
        give_verdict;
    end
endmodule

// >>> verilog/peripheral_enable_lock_mux.sv
// Purpose: key-locked peripheral enable register and shared pin steering
// Assumes: one-cycle configuration bus requests, answer one cycle later
// Notes: status word comes in on a port; its layout is held elsewhere
//
// What this block does
// - bit 4 enables video port a
// - bit 3 enables two-wire unit
// - bit 2 picks serial b over video b
// - bit 1 picks serial a over video a
// - bit 0 gives upper pins to audio
// - video a pins 2-8 shared with serial a
// - video b pins 2-8 shared with serial b
// - video pins 12-19 carry audio signals
// - exact key value unlocks configuration
// - lock register bit 0 reads locked flag
// - locked writes ignored, reads always work
// - an enable write or a wrong key relocks
// - only serial a and serial b enabled after power-up
// - read-only status register at 0x01B3F004
// - bits 6 and 5 enable video c, b
`timescale 1ns/100ps
`include "pin_steer_regs.svh"
module peripheral_enable_lock_mux
    import pin_steer_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // configuration bus
    input wire logic CFG_REQ_I,
    input wire logic CFG_WE_I,
    input wire logic [31:0] CFG_ADDR_I,
    input wire logic [31:0] CFG_WDATA_I,
    output logic CFG_ACK_O,
    output logic [31:0] CFG_RDATA_O,
    // device status word from strap logic
    input wire logic [31:0] STATUS_WORD_I,
    // peripheral enables
    output logic VIDEO_A_ON_O,
    output logic VIDEO_B_ON_O,
    output logic VIDEO_C_ON_O,
    output logic TWOWIRE_ON_O,
    output logic SERIAL_A_ON_O,
    output logic SERIAL_B_ON_O,
    output logic AUDIO_ON_O,
    // pin ownership
    output logic VIDEO_A_LOW_PINS_O,
    output logic VIDEO_B_LOW_PINS_O,
    output logic VIDEO_UPPER_PINS_O
);
    enable_t enable_reg;
    logic locked_flag_reg;
    bus_state_e state_reg;
    logic sel_enable;
    logic sel_status;
    logic sel_key;
    logic st_vid_a_low;
    logic st_ser_a;
    logic st_vid_b_low;
    logic st_ser_b;
    logic st_vid_up;
    logic st_audio;
    steer_if en_bus ();
    logic wr_req;
    logic rd_req;
    logic key_match;

    // reset image of the enables; pins show serial ownership in reset
    localparam enable_t reset_en = `ENABLE_RESET;

    // exact word match; every register sits at one full address
    function automatic logic addr_hit(
        input logic [31:0] a,
        input logic [31:0] target
    );
        addr_hit = (a == target);
    endfunction

    // strobes qualified once so the register processes stay short
    assign wr_req = CFG_REQ_I && CFG_WE_I;
    assign rd_req = CFG_REQ_I && !CFG_WE_I;
    assign key_match = CFG_WDATA_I == `UNLOCK_KEY_VALUE;

    // interface feeds the steering decode straight from the register
    assign en_bus.bits = enable_reg;
    assign sel_enable = addr_hit(CFG_ADDR_I, `ADDR_ENABLE_SELECT);
    assign sel_status = addr_hit(CFG_ADDR_I, `ADDR_STATUS_WORD);
    assign sel_key = addr_hit(CFG_ADDR_I, `ADDR_UNLOCK_KEY);

    pin_steer u_steer (
        .en(en_bus),
        .vid_a_low_o(st_vid_a_low),
        .ser_a_o(st_ser_a),
        .vid_b_low_o(st_vid_b_low),
        .ser_b_o(st_ser_b),
        .vid_up_o(st_vid_up),
        .audio_o(st_audio)
    );

    // enable register; reset value turns on only serial a and serial b
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            enable_reg <= `ENABLE_RESET;
        end else if (wr_req && sel_enable
                     && !locked_flag_reg) begin
            enable_reg <= CFG_WDATA_I[`ENABLE_MSB:0];
        end
    end

    // lock flag: only the exact key clears it, an enable write or a wrong key sets it
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            locked_flag_reg <= 1'b1;
        end else if (wr_req && sel_enable) begin
            locked_flag_reg <= 1'b1;
        end else if (wr_req && sel_key) begin
            if (key_match) begin
                locked_flag_reg <= 1'b0;
            end else begin
                locked_flag_reg <= 1'b1;
            end
        end
    end

    // answer phase: one-hot, a stray code drops back to idle unanswered
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= BUS_IDLE;
            CFG_ACK_O <= 1'b0;
        end else begin
            case (state_reg)
                BUS_IDLE: begin
                    state_reg <= CFG_REQ_I ? BUS_RESP : BUS_IDLE;
                    CFG_ACK_O <= CFG_REQ_I;
                end
                BUS_RESP: begin
                    // back-to-back requests keep the answer phase open
                    state_reg <= CFG_REQ_I ? BUS_RESP : BUS_IDLE;
                    CFG_ACK_O <= CFG_REQ_I;
                end
                default: begin
                    state_reg <= BUS_IDLE;
                    CFG_ACK_O <= 1'b0;
                end
            endcase
        end
    end

    // read data taken on the request edge; unmapped reads return zero
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CFG_RDATA_O <= 32'h00000000;
        end else begin
            if (rd_req) begin
                CFG_RDATA_O <= 32'h00000000;
                if (sel_enable) begin
                    CFG_RDATA_O[`ENABLE_MSB:0] <= enable_reg;
                end
                if (sel_status) begin
                    CFG_RDATA_O <= STATUS_WORD_I;
                end
                if (sel_key) begin
                    CFG_RDATA_O[`LOCKED_BIT] <= locked_flag_reg;
                end
            end
        end
    end

    // registered outputs, one cycle behind the enable register
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            // reset image: serial ports own the low pins, audio is off
            VIDEO_A_ON_O <= reset_en[`BIT_VID0];
            VIDEO_B_ON_O <= reset_en[`BIT_VID1];
            VIDEO_C_ON_O <= reset_en[`BIT_VID2];
            TWOWIRE_ON_O <= reset_en[`BIT_TWOWIRE];
            SERIAL_A_ON_O <= reset_en[`BIT_SER0];
            SERIAL_B_ON_O <= reset_en[`BIT_SER1];
            AUDIO_ON_O <= reset_en[`BIT_AUDIO];
            VIDEO_A_LOW_PINS_O <= !reset_en[`BIT_SER0] && reset_en[`BIT_VID0];
            VIDEO_B_LOW_PINS_O <= !reset_en[`BIT_SER1] && reset_en[`BIT_VID1];
            VIDEO_UPPER_PINS_O <= !reset_en[`BIT_AUDIO];
        end else begin
            VIDEO_A_ON_O <= enable_reg[`BIT_VID0];
            VIDEO_B_ON_O <= enable_reg[`BIT_VID1];
            VIDEO_C_ON_O <= enable_reg[`BIT_VID2];
            TWOWIRE_ON_O <= enable_reg[`BIT_TWOWIRE];
            SERIAL_A_ON_O <= st_ser_a;
            SERIAL_B_ON_O <= st_ser_b;
            AUDIO_ON_O <= st_audio;
            VIDEO_A_LOW_PINS_O <= st_vid_a_low;
            VIDEO_B_LOW_PINS_O <= st_vid_b_low;
            // upper pins go to video whenever audio is off, whatever the video enables
            VIDEO_UPPER_PINS_O <= st_vid_up;
        end
    end

    // header constants must fit the packed enable type and the data word
    if (`ENABLE_MSB + 1 != $bits(enable_t)) begin : width_check
        $error("enable field width differs from the enable type");
    end
    if ($bits(`ENABLE_RESET) != $bits(enable_t)) begin : reset_check
        $error("enable reset value width differs from the enable type");
    end
    if (`BIT_VID2 > `ENABLE_MSB) begin : field_check
        $error("an enable bit lies outside the enable field");
    end
    if (`LOCKED_BIT > 31) begin : lock_check
        $error("lock flag position lies outside the data word");
    end
endmodule

// >>> verilog/pin_steer.sv
// Purpose: pin ownership decode from the enable bits
// Assumes: enable bits come from flip-flops on the same clock
// Notes: purely combinational; the top registers the results
`timescale 1ns/100ps
`include "pin_steer_regs.svh"
module pin_steer
    import pin_steer_pkg::*;
(
    steer_if.dst en,
    output logic vid_a_low_o,
    output logic ser_a_o,
    output logic vid_b_low_o,
    output logic ser_b_o,
    output logic vid_up_o,
    output logic audio_o
);
    // lower pins go to video only if that port is on
    always_comb begin
        ser_a_o = en.bits[`BIT_SER0];
        vid_a_low_o = !en.bits[`BIT_SER0] && en.bits[`BIT_VID0];
        ser_b_o = en.bits[`BIT_SER1];
        vid_b_low_o = !en.bits[`BIT_SER1] && en.bits[`BIT_VID1];
        audio_o = en.bits[`BIT_AUDIO];
        vid_up_o = !en.bits[`BIT_AUDIO];
    end
endmodule

// >>> verilog/pin_steer_pkg.sv
// Purpose: shared types for peripheral enable/lock logic
// Assumes: nothing beyond the register header
// Notes: one-hot bus state encoding
package pin_steer_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_e;
    typedef logic [6:0] enable_t;
endpackage

// >>> verilog/pin_steer_regs.svh
// Purpose: register map and field constants for peripheral enable/lock
// Assumes: byte addresses on the configuration bus, 32-bit words
// Notes: definitions only
`ifndef PIN_STEER_REGS_SVH
`define PIN_STEER_REGS_SVH
`define ADDR_ENABLE_SELECT 32'h01B3F000
`define ADDR_STATUS_WORD 32'h01B3F004
`define ADDR_UNLOCK_KEY 32'h01B3F018
`define UNLOCK_KEY_VALUE 32'h10C0010C
`define ENABLE_RESET 7'h06
`define BIT_AUDIO 0
`define BIT_SER0 1
`define BIT_SER1 2
`define BIT_TWOWIRE 3
`define BIT_VID0 4
`define BIT_VID1 5
`define BIT_VID2 6
`define ENABLE_MSB 6
`define LOCKED_BIT 0
`define WAKE_TIME_CYCLES 128
`endif

// >>> verilog/steer_if.sv
// Purpose: carries enable bits to the pin steering module
// Assumes: single clock domain
// Notes: source drives bits, steer consumes them
`timescale 1ns/100ps
interface steer_if;
    logic [6:0] bits;
    modport src (output bits);
    modport dst (input bits);
endinterface
